// File: hdl/strap_capture.sv
// Strap sampler: weak pull-ups during reset, one capture right after reset release
`timescale 1ns/1ps
module strap_capture (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [strap_config_pkg::STRAP_HALF_WIDTH-1:0] memDataA,
	input wire logic [strap_config_pkg::STRAP_HALF_WIDTH-1:0] memDataB,
	output logic pullUpEn,
	output logic [strap_config_pkg::STRAP_WORD_WIDTH-1:0] capWord,
	output logic capLoad
);

	strap_config_pkg::capture_state_type state_q;

	// Lines 8 and 11 of bus A swap places, bus B fills the upper half
	function automatic logic [31:0] arrange(input logic [15:0] a, input logic [15:0] b);
		arrange = {b, a[15:12], a[8], a[10], a[9], a[11], a[7:0]};
	endfunction

	// Sample once after release; sampling while reset is still high would race the pads
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= strap_config_pkg::CAP_WAIT;
			capLoad <= 1'b0;
			capWord <= '0;
		end else begin
			capLoad <= 1'b0;
			case (state_q)
				strap_config_pkg::CAP_WAIT: begin
					capWord <= arrange(memDataA, memDataB) ^ strap_config_pkg::STRAP_INVERT_MASK;
					capLoad <= 1'b1;
					state_q <= strap_config_pkg::CAP_HELD;
				end
				strap_config_pkg::CAP_HELD: state_q <= strap_config_pkg::CAP_HELD;
				default: state_q <= strap_config_pkg::CAP_WAIT;
			endcase
		end
	end

	// Keepers stay on through reset and the sampling cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pullUpEn <= 1'b1;
		end else if (state_q == strap_config_pkg::CAP_WAIT) begin
			pullUpEn <= 1'b1;
		end else begin
			pullUpEn <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_strap_invert: assert property (capLoad |-> capWord[0] == !$past(memDataA[0]) && capWord[8] == $past(memDataA[11]))
		else $error("strap inversion or line order wrong");
	chk_pullup_sample: assert property (capLoad |-> $past(pullUpEn))
		else $error("pull-ups off while sampling");

endmodule // strap_capture

// File: hdl/strap_config_latch.sv
// Strap configuration latch: captures the 32-bit strap word and exposes it over APB
//
// Functional notes
// - At reset both memory data buses are sampled into the 32-bit strap word.
// - Strap lines are weakly pulled high so unstrapped lines read high.
// - Only bits 0, 15..13, 19 and 18 may change after power-up.
// - Bit 0 is ROM mapping, read/write in ROM map register bit 0.
// - Bit 1 is reserved, read-only in ROM map register bit 1.
// - Bits 2 and 17 pick bus architecture; bit 17 read-only in memory config bit 4.
// - Bit 3 low makes both video clock pins inputs, high makes them outputs.
// - Straps 4..7 and bit 8 are read-only general status bits.
// - Bit 11 low forces detectors to the voltage field (5 V at reset).
// - Bit 9 selects the wake-up port scheme.
// - Bits 13, 14, 16 pick memory mode; shown in memory config bits 5..7.
// - Bit 15 selects a 16-bit or 32-bit host.
// - Bits 18 and 19 load the read/write panel type field.
// - Bit 20 selects double-rate or single-rate local bus clock.
// - Bits 27..22 and 31..28 preload the local bus interface registers.
// - Bits 0, 1, 6, 7 are stored inverted relative to the pin.
// - Bits 10, 12 and 21 are captured but have no register view.
`timescale 1ns/1ps
module strap_config_latch #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Strap pins
	input wire logic [strap_config_pkg::STRAP_HALF_WIDTH-1:0] memDataA,
	input wire logic [strap_config_pkg::STRAP_HALF_WIDTH-1:0] memDataB,
	output logic strapPullUpEn,
	// Video clock pins, three signals each
	input wire logic videoClockOneIn,
	output logic videoClockOneOut,
	output logic videoClockOneOe,
	input wire logic videoClockTwoIn,
	output logic videoClockTwoOut,
	output logic videoClockTwoOe,
	input wire logic pixelClockSrc,
	output logic [1:0] videoClockMon,
	// Voltage detection
	input wire logic [4:0] autoVoltDetect,
	output logic [4:0] voltDetect,
	// Decoded configuration
	output logic configValid,
	output logic romMappedOut,
	output logic [1:0] busArch,
	output logic wakeAltPorts,
	output logic [2:0] memMode,
	output logic hostIs32,
	output logic [1:0] panelType,
	output logic localBusSingleRate,
	output logic [5:0] lbIfCfgLow,
	output logic [3:0] lbIfCfgHigh
);

	logic [31:0] liveWord_q;
	logic [4:0] voltField_q;
	logic autoVoltEn_q;
	logic [31:0] capWord;
	logic capLoad;
	logic [7:0] offset;
	logic accessPhase;
	logic wrAccept;

	// Sampler with its own pull-up control
	strap_capture u_capture (
		.clk(clk),
		.sys_rst(sys_rst),
		.memDataA(memDataA),
		.memDataB(memDataB),
		.pullUpEn(strapPullUpEn),
		.capWord(capWord),
		.capLoad(capLoad)
	);

	// Decode of the low address byte
	assign offset = 8'(paddr);
	assign accessPhase = psel && penable && !pready;
	// A write lands at the edge where pready is sampled high
	assign wrAccept = psel && penable && pready && pwrite && !pslverr;

	function automatic logic isMapped(input logic [7:0] off);
		case (off)
			strap_config_pkg::ROM_MAP_OFFSET,
			strap_config_pkg::GP_STATUS_OFFSET,
			strap_config_pkg::MEM_CONFIG_OFFSET,
			strap_config_pkg::PANEL_SELECT_OFFSET,
			strap_config_pkg::VOLTAGE_FIELD_OFFSET,
			strap_config_pkg::HOST_WIDTH_OFFSET,
			strap_config_pkg::STRAP_WORD_OFFSET: isMapped = 1'b1;
			default: isMapped = 1'b0;
		endcase
	endfunction

	// Read view of each register; reserved bits read zero
	function automatic logic [31:0] readReg(input logic [7:0] off, input logic [31:0] w,
			input logic [4:0] vf, input logic ae);
		readReg = '0;
		case (off)
			strap_config_pkg::ROM_MAP_OFFSET:
				readReg[1:0] = w[strap_config_pkg::SW_RSVD_ONE:strap_config_pkg::SW_ROM_OFF];
			strap_config_pkg::GP_STATUS_OFFSET: begin
				readReg[7:4] = w[strap_config_pkg::SW_GP_STATUS_LSB +: 4];
				readReg[strap_config_pkg::GP_EXTRA_POS] = w[strap_config_pkg::SW_GP_EXTRA];
			end
			strap_config_pkg::MEM_CONFIG_OFFSET: begin
				readReg[strap_config_pkg::MEM_ARCH_POS] = w[strap_config_pkg::SW_ARCH_HIGH];
				readReg[strap_config_pkg::MEM_MODE_POS] = w[strap_config_pkg::SW_MEM_LOW];
				readReg[strap_config_pkg::MEM_MODE_POS+1] = w[strap_config_pkg::SW_MEM_MID];
				readReg[strap_config_pkg::MEM_MODE_POS+2] = w[strap_config_pkg::SW_MEM_HIGH];
			end
			strap_config_pkg::PANEL_SELECT_OFFSET:
				readReg[1:0] = w[strap_config_pkg::SW_PANEL_LSB +: 2];
			strap_config_pkg::VOLTAGE_FIELD_OFFSET: begin
				readReg[4:0] = vf;
				readReg[strap_config_pkg::VOLT_AUTO_EN_POS] = ae;
			end
			strap_config_pkg::HOST_WIDTH_OFFSET:
				readReg[0] = w[strap_config_pkg::SW_HOST_WIDE];
			strap_config_pkg::STRAP_WORD_OFFSET:
				readReg = w & ~32'h00201400;
			default: readReg = '0;
		endcase
	endfunction

	// APB answer: one wait state, then pready for one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (accessPhase) begin
			pready <= 1'b1;
			pslverr <= !isMapped(offset);
			prdata <= pwrite ? 32'h00000000 : readReg(offset, liveWord_q, voltField_q, autoVoltEn_q);
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
	end

	// Latched word: loaded from the sampler, then only writable bits change
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			liveWord_q <= '0;
		end else if (capLoad) begin
			liveWord_q <= capWord;
		end else if (wrAccept) begin
			case (offset)
				strap_config_pkg::ROM_MAP_OFFSET:
					liveWord_q[strap_config_pkg::SW_ROM_OFF] <= pwdata[0];
				strap_config_pkg::MEM_CONFIG_OFFSET: begin
					liveWord_q[strap_config_pkg::SW_MEM_LOW] <= pwdata[strap_config_pkg::MEM_MODE_POS];
					liveWord_q[strap_config_pkg::SW_MEM_MID] <= pwdata[strap_config_pkg::MEM_MODE_POS+1];
				end
				strap_config_pkg::PANEL_SELECT_OFFSET:
					liveWord_q[strap_config_pkg::SW_PANEL_LSB +: 2] <= pwdata[1:0];
				strap_config_pkg::HOST_WIDTH_OFFSET:
					liveWord_q[strap_config_pkg::SW_HOST_WIDE] <= pwdata[0];
				default: liveWord_q <= liveWord_q; // Read-only views drop the write
			endcase
		end
	end

	// Voltage field and auto-detect enable, plain software registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			voltField_q <= strap_config_pkg::VOLT_FIELD_RESET;
			autoVoltEn_q <= strap_config_pkg::VOLT_AUTO_EN_RESET;
		end else if (wrAccept && offset == strap_config_pkg::VOLTAGE_FIELD_OFFSET) begin
			voltField_q <= pwdata[4:0];
			autoVoltEn_q <= pwdata[strap_config_pkg::VOLT_AUTO_EN_POS];
		end
	end

	// Valid flag rises once the sampler has delivered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			configValid <= 1'b0;
		end else if (capLoad) begin
			configValid <= 1'b1;
		end
	end

	// Detector drive: forced strap overrides the enable bit, so software cannot
	// switch on auto-detect on a board strapped for a fixed supply
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			voltDetect <= strap_config_pkg::VOLT_FIELD_RESET;
		end else if (!liveWord_q[strap_config_pkg::SW_VOLT_AUTO] || !autoVoltEn_q) begin
			voltDetect <= voltField_q;
		end else begin
			voltDetect <= autoVoltDetect;
		end
	end

	// Video clock pins: drive both only when strapped as outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			videoClockOneOe <= 1'b0;
			videoClockTwoOe <= 1'b0;
			videoClockOneOut <= 1'b0;
			videoClockTwoOut <= 1'b0;
			videoClockMon <= 2'h0;
		end else begin
			videoClockOneOe <= liveWord_q[strap_config_pkg::SW_VCLK_DIR];
			videoClockTwoOe <= liveWord_q[strap_config_pkg::SW_VCLK_DIR];
			videoClockOneOut <= pixelClockSrc;
			videoClockTwoOut <= pixelClockSrc;
			// Monitor shows the clock actually on the pins
			videoClockMon <= liveWord_q[strap_config_pkg::SW_VCLK_DIR] ?
				{pixelClockSrc, pixelClockSrc} : {videoClockTwoIn, videoClockOneIn};
		end
	end

	// Decoded configuration outputs, registered from the live word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			romMappedOut <= 1'b0;
			busArch <= 2'h0;
			wakeAltPorts <= 1'b0;
			memMode <= 3'h0;
			hostIs32 <= 1'b0;
			panelType <= 2'h0;
			localBusSingleRate <= 1'b0;
			lbIfCfgLow <= 6'h00;
			lbIfCfgHigh <= 4'h0;
		end else begin
			romMappedOut <= liveWord_q[strap_config_pkg::SW_ROM_OFF];
			busArch <= {liveWord_q[strap_config_pkg::SW_ARCH_HIGH], liveWord_q[strap_config_pkg::SW_ARCH_LOW]};
			wakeAltPorts <= liveWord_q[strap_config_pkg::SW_WAKE_SEL];
			memMode <= {liveWord_q[strap_config_pkg::SW_MEM_HIGH], liveWord_q[strap_config_pkg::SW_MEM_MID],
				liveWord_q[strap_config_pkg::SW_MEM_LOW]};
			hostIs32 <= liveWord_q[strap_config_pkg::SW_HOST_WIDE];
			panelType <= liveWord_q[strap_config_pkg::SW_PANEL_LSB +: 2];
			localBusSingleRate <= liveWord_q[strap_config_pkg::SW_LB_SINGLE];
			lbIfCfgLow <= liveWord_q[strap_config_pkg::SW_LB_LOW_LSB +: 6];
			lbIfCfgHigh <= liveWord_q[strap_config_pkg::SW_LB_HIGH_LSB +: 4];
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence resetRelease;
		$fell(sys_rst);
	endsequence

	sequence apbWrite(logic [7:0] off);
		psel && penable && pready && pwrite && !pslverr && offset == off;
	endsequence

	chk_capture_after_reset: assert property (resetRelease |-> ##1 capLoad ##1 configValid && liveWord_q == $past(capWord))
		else $error("strap word not latched after reset");
	// Reset itself must not disable this check, or it could never fire
	chk_pullup_in_reset: assert property (disable iff (1'b0) sys_rst |=> strapPullUpEn)
		else $error("pull-ups off during reset");
	chk_fixed_bits: assert property (!capLoad |=> ((liveWord_q ^ $past(liveWord_q)) & ~strap_config_pkg::STRAP_WRITABLE_MASK) == '0)
		else $error("fixed strap bit changed");
	chk_rom_write: assert property (apbWrite(strap_config_pkg::ROM_MAP_OFFSET) && !capLoad |=> ##1 romMappedOut == $past(pwdata[0], 2))
		else $error("rom map write lost");
	chk_status_readonly: assert property (apbWrite(strap_config_pkg::GP_STATUS_OFFSET) && !capLoad |=> liveWord_q == $past(liveWord_q))
		else $error("status write changed word");
	chk_clock_direction: assert property (##1 videoClockOneOe == $past(liveWord_q[strap_config_pkg::SW_VCLK_DIR]) && videoClockTwoOe == videoClockOneOe)
		else $error("video clock direction mismatch");
	chk_voltage_forced: assert property (!liveWord_q[strap_config_pkg::SW_VOLT_AUTO] |=> voltDetect == $past(voltField_q))
		else $error("voltage not forced to field");
	chk_mem_mode: assert property (!capLoad ##1 1'b1 |-> memMode == {$past(liveWord_q[16]), $past(liveWord_q[14]), $past(liveWord_q[13])})
		else $error("memory mode decode wrong");
	chk_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	chk_panel_write: assert property (apbWrite(strap_config_pkg::PANEL_SELECT_OFFSET) && !capLoad |=> ##1 panelType == $past(pwdata[1:0], 2))
		else $error("panel select write lost");

endmodule // strap_config_latch

// File: hdl/strap_config_pkg.sv
// Package: offsets, bit positions, masks and reset values for the strap configuration latch
package strap_config_pkg;

	// Strap bus geometry
	localparam int STRAP_HALF_WIDTH = 16;
	localparam int STRAP_WORD_WIDTH = 32;

	// Register byte offsets on the APB slave
	localparam logic [7:0] ROM_MAP_OFFSET = 8'h00;
	localparam logic [7:0] GP_STATUS_OFFSET = 8'h04;
	localparam logic [7:0] MEM_CONFIG_OFFSET = 8'h08;
	localparam logic [7:0] PANEL_SELECT_OFFSET = 8'h0C;
	localparam logic [7:0] VOLTAGE_FIELD_OFFSET = 8'h10;
	localparam logic [7:0] HOST_WIDTH_OFFSET = 8'h14;
	localparam logic [7:0] STRAP_WORD_OFFSET = 8'h18;

	// Positions inside the latched strap word
	localparam int SW_ROM_OFF = 0;
	localparam int SW_RSVD_ONE = 1;
	localparam int SW_ARCH_LOW = 2;
	localparam int SW_VCLK_DIR = 3;
	localparam int SW_GP_STATUS_LSB = 4;
	localparam int SW_GP_EXTRA = 8;
	localparam int SW_WAKE_SEL = 9;
	localparam int SW_VOLT_AUTO = 11;
	localparam int SW_MEM_LOW = 13;
	localparam int SW_MEM_MID = 14;
	localparam int SW_HOST_WIDE = 15;
	localparam int SW_MEM_HIGH = 16;
	localparam int SW_ARCH_HIGH = 17;
	localparam int SW_PANEL_LSB = 18;
	localparam int SW_LB_SINGLE = 20;
	localparam int SW_LB_LOW_LSB = 22;
	localparam int SW_LB_HIGH_LSB = 28;

	// Register field positions
	localparam int GP_EXTRA_POS = 3;
	localparam int GP_STATUS_POS = 4;
	localparam int MEM_ARCH_POS = 4;
	localparam int MEM_MODE_POS = 5;
	localparam int VOLT_AUTO_EN_POS = 5;

	// Sampled straps stored inverted (pull-down reads as one)
	localparam logic [31:0] STRAP_INVERT_MASK = 32'h000000C3;
	// Bits that software may rewrite through some view
	localparam logic [31:0] STRAP_WRITABLE_MASK = 32'h000CE001;

	// Voltage field after reset: all detectors at the 5 V setting
	localparam logic [4:0] VOLT_FIELD_RESET = 5'h1F;
	localparam logic VOLT_AUTO_EN_RESET = 1'h0;

	typedef enum logic [1:0] {
		CAP_WAIT,
		CAP_HELD
	} capture_state_type;

endpackage

// File: testbench/strap_pull_model.sv
// Strap resistor model: external pull-downs plus floating lines once the weak pull-ups let go
`timescale 1ns/1ps
module strap_pull_model (
	input wire logic clk,
	input wire logic pullUpEn,
	input wire logic [15:0] pullDownA,
	input wire logic [15:0] pullDownB,
	output logic [15:0] memDataA,
	output logic [15:0] memDataB
);
	logic [15:0] floatPat_q = 16'hA5A5;

	// Unpulled lines wander once the pull-ups are off, so a late sample shows up as garbage
	always @(posedge clk) begin
		floatPat_q <= ~floatPat_q;
	end

	// An external pull-down always wins; otherwise the weak pull-up or the floating pattern
	assign memDataA = pullUpEn ? ~pullDownA : (~pullDownA & floatPat_q);
	assign memDataB = pullUpEn ? ~pullDownB : (~pullDownB & ~floatPat_q);
endmodule // strap_pull_model

// File: testbench/tb.sv
// Bench for the strap configuration latch: table of strap patterns, then register and pin cases
`timescale 1ns/1ps
module tb;
	typedef struct {logic [15:0] pdA; logic [15:0] pdB; logic [31:0] word;} row_type;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, pullUpEn;
	logic [15:0] memDataA, memDataB;
	logic [15:0] pdA = 16'h0000;
	logic [15:0] pdB = 16'h0000;
	logic pixelClockSrc = 1'b0;
	logic videoClockOneOut, videoClockOneOe, videoClockTwoOut, videoClockTwoOe, configValid;
	logic romMappedOut, wakeAltPorts, hostIs32, localBusSingleRate;
	logic [1:0] videoClockMon, busArch, panelType;
	logic [2:0] memMode;
	logic [4:0] voltDetect;
	logic [5:0] lbIfCfgLow;
	logic [3:0] lbIfCfgHigh;
	logic [31:0] outVec;
	int errCount = 0;
	int numChecks = 0;
	// Expected words worked out by hand from the pin map and the inverted bits
	row_type rows[5] = '{'{16'h0000, 16'h0000, 32'hFFFFFF3C}, '{16'hFFFF, 16'hFFFF, 32'h000000C3},
		'{16'h0F0F, 16'h00FF, 32'hFF00F033}, '{16'h0100, 16'hA5A5, 32'h5A5AF73C},
		'{16'h0800, 16'h0000, 32'hFFFFFE3C}};

	always #12.5 clk = ~clk;

	strap_config_latch uut (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.memDataA(memDataA), .memDataB(memDataB), .strapPullUpEn(pullUpEn),
		.videoClockOneIn(1'b0), .videoClockOneOut(videoClockOneOut), .videoClockOneOe(videoClockOneOe),
		.videoClockTwoIn(1'b0), .videoClockTwoOut(videoClockTwoOut), .videoClockTwoOe(videoClockTwoOe),
		.pixelClockSrc(pixelClockSrc), .videoClockMon(videoClockMon), .autoVoltDetect(5'h0A),
		.voltDetect(voltDetect), .configValid(configValid), .romMappedOut(romMappedOut), .busArch(busArch),
		.wakeAltPorts(wakeAltPorts), .memMode(memMode), .hostIs32(hostIs32), .panelType(panelType),
		.localBusSingleRate(localBusSingleRate), .lbIfCfgLow(lbIfCfgLow), .lbIfCfgHigh(lbIfCfgHigh));

	strap_pull_model pulls (.clk(clk), .pullUpEn(pullUpEn), .pullDownA(pdA), .pullDownB(pdB),
		.memDataA(memDataA), .memDataB(memDataB));

	// All decoded configuration outputs packed in one word for a single comparison
	assign outVec = {3'h0, romMappedOut, busArch, wakeAltPorts, memMode, hostIs32, panelType,
		localBusSingleRate, lbIfCfgLow, lbIfCfgHigh, videoClockOneOe, videoClockTwoOe, configValid, voltDetect};

	function automatic logic [31:0] expOut(input logic [31:0] w);
		return {3'h0, w[0], w[17], w[2], w[9], w[16], w[14], w[13], w[15], w[19], w[18], w[20], w[27:22],
			w[31:28], w[3], w[3], 1'b1, 5'h1F};
	endfunction

	function automatic logic [31:0] expReg(input logic [7:0] a, input logic [31:0] w);
		case (a)
			8'h00: return {30'h0, w[1], w[0]};
			8'h04: return {24'h0, w[7:4], w[8], 3'h0};
			8'h08: return {24'h0, w[16], w[14], w[13], w[17], 4'h0};
			8'h0C: return {30'h0, w[19:18]};
			8'h10: return 32'h0000001F;
			8'h14: return {31'h0, w[15]};
			default: return w & 32'hFFDFEBFF;
		endcase
	endfunction

	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED at %0t: reg got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkOut(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED at %0t: pins got %h expected %h", $time, got, exp);
		end
	endtask

	// Master holds every request signal until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) errCount++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic doReset();
		sysRst <= 1'b1;
		repeat (6) @(posedge clk);
		chkOut({25'h0, pullUpEn, configValid, voltDetect}, 32'h0000005F);
		sysRst <= 1'b0;
		repeat (4) @(posedge clk);
		chkOut({31'h0, pullUpEn}, 32'h0);
	endtask

	task automatic endSim();
		$display("Comparisons %0d, mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		errCount++;
		endSim();
	end

	initial begin
		foreach (rows[r]) begin
			pdA <= rows[r].pdA;
			pdB <= rows[r].pdB;
			doReset();
			chkOut(outVec, expOut(rows[r].word));
			for (int i = 0; i < 7; i++) begin
				apb(1'b0, 8'(i * 4), 32'h0);
				chkReg(rd, expReg(8'(i * 4), rows[r].word));
				chkReg({31'h0, err}, 32'h00000000);
			end
		end
		// Rewrite every writable view, poke read-only ones, then move the strap pins
		apb(1'b1, strap_config_pkg::ROM_MAP_OFFSET, 32'h00000003);
		apb(1'b0, strap_config_pkg::ROM_MAP_OFFSET, 32'h0);
		chkReg(rd, 32'h00000001);
		apb(1'b1, strap_config_pkg::GP_STATUS_OFFSET, 32'h00000000);
		apb(1'b0, strap_config_pkg::GP_STATUS_OFFSET, 32'h0);
		chkReg(rd, 32'h00000030);
		apb(1'b1, strap_config_pkg::MEM_CONFIG_OFFSET, 32'h00000000);
		apb(1'b0, strap_config_pkg::MEM_CONFIG_OFFSET, 32'h0);
		chkReg(rd, 32'h00000090);
		apb(1'b1, strap_config_pkg::PANEL_SELECT_OFFSET, 32'h00000001);
		apb(1'b0, strap_config_pkg::PANEL_SELECT_OFFSET, 32'h0);
		chkReg(rd, 32'h00000001);
		apb(1'b1, strap_config_pkg::HOST_WIDTH_OFFSET, 32'h00000000);
		apb(1'b0, strap_config_pkg::HOST_WIDTH_OFFSET, 32'h0);
		chkReg(rd, 32'h00000000);
		apb(1'b1, strap_config_pkg::STRAP_WORD_OFFSET, 32'h00000000);
		apb(1'b1, 8'h1C, 32'hFFFFFFFF);
		chkReg({31'h0, err}, 32'h00000001);
		apb(1'b0, 8'h1C, 32'h0);
		chkReg(rd, 32'h00000000);
		chkReg({31'h0, err}, 32'h00000001);
		pdA <= 16'hFFFF;
		pdB <= 16'hFFFF;
		repeat (4) @(posedge clk);
		chkOut(outVec, expOut(32'hFFF71E3D));
		pixelClockSrc <= 1'b1;
		repeat (3) @(posedge clk);
		chkOut({28'h0, videoClockOneOut, videoClockTwoOut, videoClockMon}, 32'h0000000F);
		// Voltage field with automatic detect allowed, then with it forced off
		apb(1'b1, strap_config_pkg::VOLTAGE_FIELD_OFFSET, 32'h00000025);
		apb(1'b0, strap_config_pkg::VOLTAGE_FIELD_OFFSET, 32'h0);
		chkReg(rd, 32'h00000025);
		repeat (3) @(posedge clk);
		chkOut({27'h0, voltDetect}, 32'h0000000A);
		pdA <= 16'h0100;
		pdB <= 16'h0000;
		doReset();
		apb(1'b1, strap_config_pkg::VOLTAGE_FIELD_OFFSET, 32'h00000025);
		repeat (3) @(posedge clk);
		chkOut({27'h0, voltDetect}, 32'h00000005);
		endSim();
	end
endmodule // tb
